// ===== rtl/dual_adc_regs.vh
/*
  Constants for the dual simultaneous-sampling converter read-out block.
  Assumes a 200 MHz system clock; included by bare name from the rtl files.
*/
`ifndef DUAL_ADC_REGS_VH
`define DUAL_ADC_REGS_VH
`define CLK_PERIOD_PS 5000
`define CONV_TIME_FAST_PS 3600000
`define CONV_TIME_SLEEP_PS 6000000
`define CONV_CYCLES_FAST ((`CONV_TIME_FAST_PS) / (`CLK_PERIOD_PS))
`define CONV_CYCLES_SLEEP ((`CONV_TIME_SLEEP_PS) / (`CLK_PERIOD_PS))
`define RESULT_WIDTH 12
`define RESULT_MSB 11
`define CODING_TWOS 1'b1
`define CODING_BINARY 1'b0
`define RESET_RESULT 12'h000
`endif

// ===== rtl/pin_sync.v
/*
  Three-stage synchroniser for asynchronous pin levels.
  Assumes the caller debounces nothing; the output changes only when stages two and three agree.
*/
`timescale 1ns/1ps
`include "dual_adc_regs.vh"
module pin_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
  input wire sys_clk, // System clock.
  input wire rstn, // Asynchronous reset, active low.
  input wire clk_en, // Clock enable.
  input wire [WIDTH-1:0] pin_in, // Asynchronous pin levels.
  output reg [WIDTH-1:0] level_q // Filtered synchronous levels.
);
  reg [WIDTH-1:0] s1_q;
  reg [WIDTH-1:0] s2_q;
  reg [WIDTH-1:0] s3_q;
  integer i;
  always @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s1_q <= INIT;
      s2_q <= INIT;
      s3_q <= INIT;
      level_q <= INIT;
    end
    else if (clk_en)
    begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (i = 0; i < WIDTH; i = i + 1)
      begin
        if (s2_q[i] == s3_q[i])
          level_q[i] <= s3_q[i];
      end
    end
  end
endmodule // pin_sync

// ===== rtl/dual_adc_convert_readout.v
/*
  Conversion control and parallel read-out of a dual simultaneous-sampling 12-bit converter.
  Assumes the sample values arrive from the analog front end as unsigned offset codes on the
  system clock; host strobes are asynchronous pins and pass the three-stage synchroniser.
*/
// Contract
// - A falling convert-start edge holds both track/holds and starts both converters together.
// - Busy rises on the convert-start falling edge and stays high until conversion ends.
// - Result lines are driven only while read strobe and chip select are both low, select picks the pair.
// - With select low, reads after a conversion give channel A input 1 then input 2.
// - With select high, reads give channel B input 1 then input 2.
// - The result bus is twelve bits, bit 11 most significant, and floats when not enabled.
// - Bipolar versions present results in two's complement.
// - The unipolar version presents results in straight binary.
// - Chip select is active low and the device is selected only while it is low.
// - Conversion ends within 3.6 us in high sampling mode or 6 us in auto sleep mode.
// - Conversion is timed from an internal clock with no host clock.
`timescale 1ns/1ps
`include "dual_adc_regs.vh"
module dual_adc_convert_readout #(
  parameter BIPOLAR = 1,
  parameter CONV_CYCLES_FAST = `CONV_CYCLES_FAST,
  parameter CONV_CYCLES_SLEEP = `CONV_CYCLES_SLEEP
) (
  input wire sys_clk, // Internal conversion clock.
  input wire rstn, // Asynchronous reset, active low.
  input wire clk_en, // Clock enable, freezes state when low.
  input wire convert_start_n, // Convert start pin, active low.
  input wire chip_select_n, // Chip select pin, active low.
  input wire read_n, // Read strobe pin, active low.
  input wire channel_pair_select, // Low picks channel A, high channel B.
  input wire auto_sleep, // High selects the auto sleep mode timing.
  input wire [11:0] analog_in_a_first, // Sampled code of channel A input 1.
  input wire [11:0] analog_in_a_second, // Sampled code of channel A input 2.
  input wire [11:0] analog_in_b_first, // Sampled code of channel B input 1.
  input wire [11:0] analog_in_b_second, // Sampled code of channel B input 2.
  output reg busy, // High while converting.
  output reg track_hold, // High while both track/holds are in hold.
  output reg [11:0] result_bus_out, // Result bus drive value.
  output reg [11:0] result_bus_oe // Result bus output enables, high drives.
);
  localparam ST_IDLE = 2'b01;
  localparam ST_CONV = 2'b10;
  localparam CNT_W = 13;

  wire start_n_s;
  wire cs_n_s;
  wire rd_n_s;
  wire sel_s;
  reg start_n_prev_q;
  reg rd_active_prev_q;
  reg [1:0] state_q;
  reg [CNT_W-1:0] cnt_q;
  reg [11:0] held_a1_q;
  reg [11:0] held_a2_q;
  reg [11:0] held_b1_q;
  reg [11:0] held_b2_q;
  reg [11:0] res_a1_q;
  reg [11:0] res_a2_q;
  reg [11:0] res_b1_q;
  reg [11:0] res_b2_q;
  reg second_a_q;
  reg second_b_q;
  reg [11:0] bus_word_d;

  function [11:0] code_of;
    input [11:0] raw;
    begin
      if (BIPOLAR != 0)
        code_of = {~raw[`RESULT_MSB], raw[`RESULT_MSB-1:0]};
      else
        code_of = raw;
    end
  endfunction

  // Picks the word of a pair that the read pointer of that pair points at.
  function [11:0] pair_word;
    input second;
    input [11:0] first_word;
    input [11:0] second_word;
    begin
      if (second)
        pair_word = second_word;
      else
        pair_word = first_word;
    end
  endfunction

  // Host strobes are asynchronous pins, so every edge reaches the logic four cycles late.
  pin_sync #(
    .WIDTH(4),
    .INIT(4'hF)
  ) u_sync (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .clk_en(clk_en),
    .pin_in({convert_start_n, chip_select_n, read_n, channel_pair_select}),
    .level_q({start_n_s, cs_n_s, rd_n_s, sel_s})
  );

  wire start_fall = start_n_prev_q & ~start_n_s;
  wire rd_active = ~cs_n_s & ~rd_n_s;
  wire rd_end = rd_active_prev_q & ~rd_active;
  // The mode is taken at the start edge and the counter carries it through the conversion.
  wire [CNT_W-1:0] conv_len = auto_sleep ? CONV_CYCLES_SLEEP[CNT_W-1:0] : CONV_CYCLES_FAST[CNT_W-1:0];

  // Word that the bus shows next, for the pair selected at this moment.
  always @*
  begin
    if (sel_s)
      bus_word_d = pair_word(second_b_q, res_b1_q, res_b2_q);
    else
      bus_word_d = pair_word(second_a_q, res_a1_q, res_a2_q);
  end

  always @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_q <= ST_IDLE;
      cnt_q <= {CNT_W{1'b0}};
      busy <= 1'b0;
      track_hold <= 1'b0;
      held_a1_q <= `RESET_RESULT;
      held_a2_q <= `RESET_RESULT;
      held_b1_q <= `RESET_RESULT;
      held_b2_q <= `RESET_RESULT;
      res_a1_q <= `RESET_RESULT;
      res_a2_q <= `RESET_RESULT;
      res_b1_q <= `RESET_RESULT;
      res_b2_q <= `RESET_RESULT;
    end
    else if (clk_en)
    begin
      case (state_q)
        // A start edge seen while converting is ignored here; only the read pointers react to it.
        ST_IDLE:
        begin
          if (start_fall)
          begin
            state_q <= ST_CONV;
            cnt_q <= conv_len - 13'h0001;
            busy <= 1'b1;
            track_hold <= 1'b1;
            held_a1_q <= analog_in_a_first;
            held_a2_q <= analog_in_a_second;
            held_b1_q <= analog_in_b_first;
            held_b2_q <= analog_in_b_second;
          end
        end
        // Reads during a conversion are not held off; they return the previous results.
        ST_CONV:
        begin
          if (cnt_q == {CNT_W{1'b0}})
          begin
            state_q <= ST_IDLE;
            busy <= 1'b0;
            track_hold <= 1'b0;
            res_a1_q <= code_of(held_a1_q);
            res_a2_q <= code_of(held_a2_q);
            res_b1_q <= code_of(held_b1_q);
            res_b2_q <= code_of(held_b2_q);
          end
          else
            cnt_q <= cnt_q - 13'h0001;
        end
        default:
        begin
          state_q <= ST_IDLE;
          busy <= 1'b0;
          track_hold <= 1'b0;
        end
      endcase
    end
  end

  // Edge detectors on the filtered levels; both reset to the idle level of their pins,
  // so that leaving reset never looks like a start or the end of a read.
  always @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      start_n_prev_q <= 1'b1;
      rd_active_prev_q <= 1'b0;
    end
    else if (clk_en)
    begin
      start_n_prev_q <= start_n_s;
      rd_active_prev_q <= rd_active;
    end
  end

  // Read pointers and the result bus. A pointer advances when a read ends, for the pair
  // selected at that moment; a start in the same cycle wins, so the next read gives input 1.
  always @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      second_a_q <= 1'b0;
      second_b_q <= 1'b0;
      result_bus_out <= `RESET_RESULT;
      result_bus_oe <= 12'h000;
    end
    else if (clk_en)
    begin
      if (start_fall)
      begin
        second_a_q <= 1'b0;
        second_b_q <= 1'b0;
      end
      else if (rd_end)
      begin
        if (sel_s)
          second_b_q <= ~second_b_q;
        else
          second_a_q <= ~second_a_q;
      end
      if (rd_active)
      begin
        result_bus_oe <= 12'hFFF;
        result_bus_out <= bus_word_d;
      end
      else
        result_bus_oe <= 12'h000;
    end
  end
endmodule // dual_adc_convert_readout

// ===== bench/dual_adc_props.sv
/* Port checker for the converter read-out block.
   Assumes conversion counts of 8 and 12 cycles. */
`timescale 1ns/1ps
module dual_adc_props (
  input wire sys_clk, // Clock.
  input wire rstn, // Reset, active low.
  input wire convert_start_n, // Start pin.
  input wire chip_select_n, // Select pin.
  input wire read_n, // Read pin.
  input wire busy, // Busy flag.
  input wire track_hold, // Hold state.
  input wire [11:0] result_bus_oe // Drive enables.
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  a_hold_is_busy: assert property (busy == track_hold) else $error("hold differs from busy");
  a_busy_cause: assert property ($rose(busy) |->
    !$past(convert_start_n, 2) && $past(convert_start_n, 7)) else $error("busy rose without start");
  a_busy_stays: assert property ($rose(busy) |-> busy [*8]) else $error("busy short");
  a_conv_ends: assert property ($rose(busy) |-> ##[8:12] $fell(busy)) else $error("busy long");
  a_oe_cause: assert property ($rose(|result_bus_oe) |->
    $past(!chip_select_n && !read_n, 2)) else $error("drive without read");
  a_oe_whole: assert property (result_bus_oe == 12'h000 || result_bus_oe == 12'hFFF) else $error("split");
  a_unsel_float: assert property (chip_select_n [*8] |-> result_bus_oe == 12'h000) else $error("drives");
  a_read_drives: assert property ((!chip_select_n && !read_n) [*8] |-> &result_bus_oe) else $error("float");
  cover property ($fell(busy));
  cover property ($rose(|result_bus_oe));
  cover property (chip_select_n && !read_n);
endmodule // dual_adc_props

// ===== bench/host_bus.sv
/* Host model driving the converter's control pins.
   Assumes the pins are synchronised inside the device. */
`timescale 1ns/1ps
module host_bus (
  input wire sys_clk, // Clock.
  input wire [11:0] result_bus_out, // Bus value.
  input wire [11:0] result_bus_oe, // Bus enables.
  output reg convert_start_n = 1'b1, // Start pin.
  output reg chip_select_n = 1'b1, // Select pin.
  output reg read_n = 1'b1, // Read pin.
  output reg channel_pair_select = 1'b0 // Pair select.
);
  task start;
    begin
      repeat (60) @(posedge sys_clk);
      convert_start_n <= 1'b0;
      repeat (8) @(posedge sys_clk);
      convert_start_n <= 1'b1;
    end
  endtask
  task rd(input logic cs_n, input logic sel, output logic [11:0] d, output logic [11:0] oe);
    begin
      @(posedge sys_clk) channel_pair_select <= sel;
      repeat (6) @(posedge sys_clk);
      chip_select_n <= cs_n;
      read_n <= 1'b0;
      repeat (8) @(posedge sys_clk);
      d = result_bus_out;
      oe = result_bus_oe;
      chip_select_n <= 1'b1;
      read_n <= 1'b1;
      repeat (8) @(posedge sys_clk);
    end
  endtask
endmodule // host_bus

// ===== bench/tb.sv
/* Self-checking bench for the converter read-out block.
   Assumes short conversion counts; DUT codes bipolar results, DUT_U unipolar ones. */
`timescale 1ns/1ps
module tb;
  reg sys_clk = 1'b0;
  reg rstn = 1'b0;
  reg auto_sleep = 1'b0;
  reg clk_en = 1'b1;
  reg [11:0] a1 = 12'h123, a2 = 12'h9AB, b1 = 12'h0F0, b2 = 12'hE07;
  wire convert_start_n, chip_select_n, read_n, channel_pair_select, busy, track_hold;
  wire [11:0] result_bus_out, result_bus_oe;
  wire [11:0] uni_out, uni_oe;
  reg [11:0] uni_word = 12'h000;
  integer errors = 0, tests_run = 0, i;
  reg [11:0] d, oe;
  always #2.5 sys_clk = ~sys_clk;
  dual_adc_convert_readout #(.BIPOLAR(1), .CONV_CYCLES_FAST(8), .CONV_CYCLES_SLEEP(12)) DUT (.sys_clk(sys_clk),
    .rstn(rstn), .clk_en(clk_en), .convert_start_n(convert_start_n), .chip_select_n(chip_select_n),
    .read_n(read_n), .channel_pair_select(channel_pair_select), .auto_sleep(auto_sleep),
    .analog_in_a_first(a1), .analog_in_a_second(a2), .analog_in_b_first(b1), .analog_in_b_second(b2),
    .busy(busy), .track_hold(track_hold), .result_bus_out(result_bus_out), .result_bus_oe(result_bus_oe));
  dual_adc_convert_readout #(.BIPOLAR(0), .CONV_CYCLES_FAST(8), .CONV_CYCLES_SLEEP(12)) DUT_U (.sys_clk(sys_clk),
    .rstn(rstn), .clk_en(clk_en), .convert_start_n(convert_start_n), .chip_select_n(chip_select_n),
    .read_n(read_n), .channel_pair_select(channel_pair_select), .auto_sleep(auto_sleep),
    .analog_in_a_first(a1), .analog_in_a_second(a2), .analog_in_b_first(b1), .analog_in_b_second(b2),
    .busy(), .track_hold(), .result_bus_out(uni_out), .result_bus_oe(uni_oe));
  // Keeps the last word that the unipolar instance drove during a read.
  always @(posedge sys_clk)
  begin
    if (uni_oe == 12'hFFF)
      uni_word <= uni_out;
  end
  host_bus host (.sys_clk(sys_clk), .result_bus_out(result_bus_out), .result_bus_oe(result_bus_oe),
    .convert_start_n(convert_start_n), .chip_select_n(chip_select_n), .read_n(read_n),
    .channel_pair_select(channel_pair_select));
  task chk(input [11:0] got, input [11:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp)
      begin
        errors = errors + 1;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task conv(input logic slp);
    begin
      @(posedge sys_clk) auto_sleep <= slp;
      host.start;
      repeat (7) @(posedge sys_clk);
      #1;
      chk({11'h000, busy}, {11'h000, slp});
      for (i = 0; i < 20 && busy !== 1'b0; i = i + 1) @(posedge sys_clk);
      if (busy !== 1'b0)
      begin
        errors = errors + 1;
        $display("[FAIL] t=%0t busy=%h exp=%h", $time, busy, 1'b0);
        close_out;
      end
    end
  endtask
  task test_pairs;
    begin
      conv(1'b0);
      host.rd(1'b0, 1'b0, d, oe);
      chk(d, a1 ^ 12'h800);
      chk(oe, 12'hFFF);
      chk(uni_word, a1);
      host.rd(1'b0, 1'b0, d, oe);
      chk(d, a2 ^ 12'h800);
      host.rd(1'b0, 1'b1, d, oe);
      chk(d, b1 ^ 12'h800);
      host.rd(1'b0, 1'b1, d, oe);
      chk(d, b2 ^ 12'h800);
      chk(uni_word, b2);
      $display("test_pairs done");
    end
  endtask
  task test_restart;
    begin
      conv(1'b1);
      host.rd(1'b0, 1'b0, d, oe);
      chk(d, a1 ^ 12'h800);
      host.rd(1'b1, 1'b0, d, oe);
      chk(oe, 12'h000);
      a1 <= 12'h456;
      conv(1'b0);
      host.rd(1'b0, 1'b0, d, oe);
      chk(d, a1 ^ 12'h800);
      $display("test_restart done");
    end
  endtask
  task test_freeze;
    begin
      clk_en <= 1'b0;
      host.start;
      repeat (12) @(posedge sys_clk);
      chk({11'h000, busy}, 12'h000);
      clk_en <= 1'b1;
      repeat (12) @(posedge sys_clk);
      chk({11'h000, busy}, 12'h000);
      $display("test_freeze done");
    end
  endtask
  task test_reset;
    begin
      host.start;
      rstn <= 1'b0;
      @(posedge sys_clk);
      #1;
      chk({11'h000, busy}, 12'h000);
      chk(result_bus_oe, 12'h000);
      repeat (3) @(posedge sys_clk);
      rstn <= 1'b1;
      repeat (20) @(posedge sys_clk);
      chk({11'h000, busy}, 12'h000);
      conv(1'b0);
      host.rd(1'b0, 1'b0, d, oe);
      chk(d, a1 ^ 12'h800);
      $display("test_reset done");
    end
  endtask
  task close_out;
    begin
      $display("checks=%0d mismatches=%0d", tests_run, errors);
      if (errors == 0 && tests_run > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  initial
  begin
    repeat (16) @(posedge sys_clk);
    rstn <= 1'b1;
    test_pairs;
    test_restart;
    test_freeze;
    test_reset;
    close_out;
  end
endmodule // tb
bind dual_adc_convert_readout dual_adc_props u_props (.sys_clk(sys_clk), .rstn(rstn),
  .convert_start_n(convert_start_n), .chip_select_n(chip_select_n), .read_n(read_n), .busy(busy),
  .track_hold(track_hold), .result_bus_oe(result_bus_oe));
